// >>> common/sslind_flash_if.sv
// Flash phase carrier between the prescaler and the LED encoder.
`timescale 1ns/10ps
`default_nettype none
interface sslind_flash_if;
  logic phase;
  modport src (output phase);
  modport snk (input phase);
endinterface
`default_nettype wire

// >>> common/sslind_pkg.sv
// Constants shared by the safety status LED indicator block.
// Functional notes
// - Output-state LED steady while safety outputs are on, dark while off.
// - Start LED dark when not met, steady when met, flashing while waiting.
// - One LED per safety input, steady when active, dark when inactive.
// - Any alert flashes error LED with related input LEDs and forces safe state.
// - Alert safe state ends by itself once its cause has gone.
// - Pair synchronization timeout raises alert, input LEDs flash in antiphase.
// - Interlock flashes both LEDs in phase; outputs wait for one quiet second.
// - Equal inputs where antivalence is needed: alert, both input LEDs steady.
// - Detected error: error LED steady, safe state latched until power cycle.
// - Configuration error lights all status LEDs; general error flashes them.
// - Supply fault: error LED steady, power LED flashing.
// - Own output fault: error LED steady, output-state LED flashing.
// - Extension output fault: error LED steady, state and start LEDs flash.
// - Start input cross circuit: error LED steady, start LED flashing.
// - Cross circuit at one input: error LED steady, that input LED flashing.
// - Cross circuit between two inputs: both input LEDs flash in phase.
// - Selector positions are taken once after power-up only.
// - Any selector change while powered is a latched configuration error.
package sslind_pkg;

  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;
  localparam int unsigned QUIET_MS = 1000;
  localparam int unsigned QUIET_CYC = QUIET_MS * CLK_KHZ;
  localparam int unsigned CNT_W = 28;
  localparam logic [1:0] BOOT_LAST = 2'h2;

  localparam int unsigned NIN = 3;
  localparam int unsigned NPAIR = 2;
  localparam int unsigned SEL_W = 4;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ERR = 8'h08;
  localparam logic [7:0] OFS_ALERT = 8'h0c;
  localparam logic [31:0] CTRL_RST = 32'h0;
  localparam int unsigned CTRL_FORCE_BIT = 0;

  localparam int unsigned ST_OUT_BIT = 0;
  localparam int unsigned ST_ALERT_BIT = 1;
  localparam int unsigned ST_ERR_BIT = 2;
  localparam int unsigned ST_APP_LSB = 8;
  localparam int unsigned ST_START_LSB = 12;

  localparam int unsigned ERR_W = 16;
  localparam int unsigned ERR_CFG_BIT = 0;
  localparam int unsigned ERR_GEN_BIT = 1;
  localparam int unsigned ERR_SUP_BIT = 2;
  localparam int unsigned ERR_OUT_BIT = 3;
  localparam int unsigned ERR_EXT_BIT = 4;
  localparam int unsigned ERR_SXC_BIT = 5;
  localparam int unsigned ERR_IXC_LSB = 8;
  localparam int unsigned ERR_PXC_LSB = 12;

  localparam int unsigned AL_SYNC_LSB = 0;
  localparam int unsigned AL_ILK_LSB = 4;
  localparam int unsigned AL_ANTI_LSB = 8;

  typedef enum logic [1:0] {
    MODE_RUN = 2'h0,
    MODE_ALERT = 2'h1,
    MODE_ERROR = 2'h3
  } sslind_mode_type;

endpackage

// >>> core/sslind_flasher.sv
// Flash prescaler producing the common blink phase.
`timescale 1ns/10ps
`default_nettype none
module sslind_flasher #(
  parameter int unsigned HALF_CYC = sslind_pkg::FLASH_HALF_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  sslind_flash_if.src flash
);

  logic [sslind_pkg::CNT_W-1:0] cnt_r;
  logic [sslind_pkg::CNT_W-1:0] cnt_nxt;
  logic phase_r;
  logic phase_nxt;

  // One free-running phase keeps every flashing LED on the panel in step.
  always_comb begin
    cnt_nxt = cnt_r + 1'b1;
    phase_nxt = phase_r;
    if (cnt_r == sslind_pkg::CNT_W'(HALF_CYC - 1)) begin
      cnt_nxt = '0;
      phase_nxt = ~phase_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      phase_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign flash.phase = phase_r;

endmodule
`default_nettype wire

// >>> core/sslind_top.sv
// Safety status LED indicator: alert and error tracking with LED encoding.
`timescale 1ns/10ps
`default_nettype none
module sslind_top #(
  parameter int unsigned FLASH_HALF_CYC = sslind_pkg::FLASH_HALF_CYC,
  parameter int unsigned QUIET_CYC = sslind_pkg::QUIET_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [sslind_pkg::NIN-1:0] in_pin_i,
  input wire logic [sslind_pkg::SEL_W-1:0] sel_app_pin_i,
  input wire logic [sslind_pkg::SEL_W-1:0] sel_start_pin_i,
  input wire logic out_request_i,
  input wire logic start_met_i,
  input wire logic start_wait_i,
  input wire logic [sslind_pkg::NPAIR-1:0] sync_timeout_i,
  input wire logic [sslind_pkg::NPAIR-1:0] interlock_i,
  input wire logic [sslind_pkg::NPAIR-1:0] antivalent_i,
  input wire logic general_fault_i,
  input wire logic supply_fault_i,
  input wire logic out_fault_i,
  input wire logic ext_fault_i,
  input wire logic start_xc_i,
  input wire logic [sslind_pkg::NIN-1:0] in_xc_i,
  input wire logic [sslind_pkg::NPAIR-1:0] pair_xc_i,
  output logic safe_out_en_o,
  output logic led_power_o,
  output logic led_state_o,
  output logic led_start_o,
  output logic [sslind_pkg::NIN-1:0] led_in_o,
  output logic led_error_o,
  output logic [sslind_pkg::SEL_W-1:0] cfg_app_o,
  output logic [sslind_pkg::SEL_W-1:0] cfg_start_o
);

  localparam int unsigned NIN = sslind_pkg::NIN;
  localparam int unsigned NPAIR = sslind_pkg::NPAIR;
  localparam int unsigned SW2 = 2 * sslind_pkg::SEL_W;
  localparam int unsigned CW = sslind_pkg::CNT_W;

  // Reset release synchroniser.
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Pin synchronisers for input terminals and selectors.
  logic [NIN-1:0] in_meta_r;
  logic [NIN-1:0] in_sync_r;
  logic [SW2-1:0] sel_meta_r;
  logic [SW2-1:0] sel_sync_r;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_r <= '0;
      in_sync_r <= '0;
      sel_meta_r <= '0;
      sel_sync_r <= '0;
    end else begin
      in_meta_r <= in_pin_i;
      in_sync_r <= in_meta_r;
      sel_meta_r <= {sel_app_pin_i, sel_start_pin_i};
      sel_sync_r <= sel_meta_r;
    end
  end

  sslind_flash_if flash_bus ();

  sslind_flasher #(
    .HALF_CYC(FLASH_HALF_CYC)
  ) u_flasher (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .flash(flash_bus)
  );

  logic ph;
  assign ph = flash_bus.phase;

  // Selector capture after the synchronisers have settled.
  logic [1:0] boot_cnt_r;
  logic [1:0] boot_cnt_nxt;
  logic cap_done_r;
  logic cap_done_nxt;
  logic [SW2-1:0] sel_cap_r;
  logic [SW2-1:0] sel_cap_nxt;
  logic cfg_mismatch;

  always_comb begin
    boot_cnt_nxt = boot_cnt_r;
    cap_done_nxt = cap_done_r;
    sel_cap_nxt = sel_cap_r;
    if (!cap_done_r) begin
      if (boot_cnt_r == sslind_pkg::BOOT_LAST) begin
        sel_cap_nxt = sel_sync_r;
        cap_done_nxt = 1'b1;
      end else begin
        boot_cnt_nxt = boot_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_r <= '0;
      cap_done_r <= 1'b0;
      sel_cap_r <= '0;
    end else begin
      boot_cnt_r <= boot_cnt_nxt;
      cap_done_r <= cap_done_nxt;
      sel_cap_r <= sel_cap_nxt;
    end
  end

  assign cfg_mismatch = cap_done_r && (sel_sync_r != sel_cap_r);

  // Latched errors; only a reset clears them, as a power cycle would.
  logic [sslind_pkg::ERR_W-1:0] err_r;
  logic [sslind_pkg::ERR_W-1:0] err_nxt;
  logic [sslind_pkg::ERR_W-1:0] err_now;
  logic err_any;

  always_comb begin
    err_now = '0;
    err_now[sslind_pkg::ERR_CFG_BIT] = cfg_mismatch;
    err_now[sslind_pkg::ERR_GEN_BIT] = general_fault_i;
    err_now[sslind_pkg::ERR_SUP_BIT] = supply_fault_i;
    err_now[sslind_pkg::ERR_OUT_BIT] = out_fault_i;
    err_now[sslind_pkg::ERR_EXT_BIT] = ext_fault_i;
    err_now[sslind_pkg::ERR_SXC_BIT] = start_xc_i;
    err_now[sslind_pkg::ERR_IXC_LSB +: NIN] = in_xc_i;
    err_now[sslind_pkg::ERR_PXC_LSB +: NPAIR] = pair_xc_i;
    err_nxt = err_r | err_now;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      err_r <= '0;
    end else begin
      err_r <= err_nxt;
    end
  end

  assign err_any = |err_r;

  // Interlock hold per pair: released after both inputs stay low long enough.
  logic [NPAIR-1:0] ilk_r;
  logic [NPAIR-1:0] ilk_nxt;
  logic [NPAIR-1:0][CW-1:0] quiet_r;
  logic [NPAIR-1:0][CW-1:0] quiet_nxt;

  always_comb begin
    ilk_nxt = ilk_r;
    quiet_nxt = quiet_r;
    for (int p = 0; p < NPAIR; p++) begin
      if (interlock_i[p]) begin
        ilk_nxt[p] = 1'b1;
        quiet_nxt[p] = '0;
      end else if (ilk_r[p]) begin
        if (!in_sync_r[p] && !in_sync_r[p+1]) begin
          if (quiet_r[p] == CW'(QUIET_CYC - 1)) begin
            ilk_nxt[p] = 1'b0;
            quiet_nxt[p] = '0;
          end else begin
            quiet_nxt[p] = quiet_r[p] + 1'b1;
          end
        end else begin
          quiet_nxt[p] = '0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ilk_r <= '0;
      quiet_r <= '0;
    end else begin
      ilk_r <= ilk_nxt;
      quiet_r <= quiet_nxt;
    end
  end

  logic alert_any;
  assign alert_any = |{sync_timeout_i, ilk_r, antivalent_i};

  // Operating mode and register block state.
  sslind_pkg::sslind_mode_type mode_r;
  sslind_pkg::sslind_mode_type mode_nxt;
  logic out_en_r;
  logic out_en_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  always_comb begin
    case (mode_r)
      sslind_pkg::MODE_RUN: begin
        if (err_any) begin
          mode_nxt = sslind_pkg::MODE_ERROR;
        end else if (alert_any) begin
          mode_nxt = sslind_pkg::MODE_ALERT;
        end else begin
          mode_nxt = sslind_pkg::MODE_RUN;
        end
      end
      sslind_pkg::MODE_ALERT: begin
        if (err_any) begin
          mode_nxt = sslind_pkg::MODE_ERROR;
        end else if (!alert_any) begin
          mode_nxt = sslind_pkg::MODE_RUN;
        end else begin
          mode_nxt = sslind_pkg::MODE_ALERT;
        end
      end
      sslind_pkg::MODE_ERROR: mode_nxt = sslind_pkg::MODE_ERROR;
      default: mode_nxt = sslind_pkg::MODE_ERROR;
    endcase
  end

  // Outputs drop one edge after a sync timeout or antivalence alert, two after a fault or interlock request, the same edge on which the mode follows.
  assign out_en_nxt = (mode_r == sslind_pkg::MODE_RUN) && !alert_any && !err_any &&
                      out_request_i && !ctrl_r[sslind_pkg::CTRL_FORCE_BIT];

  // Read data is captured in the setup cycle so the access cycle needs no wait.
  always_comb begin
    ctrl_nxt = ctrl_r;
    prdata_nxt = prdata_r;
    if (psel_i && penable_i && pwrite_i && paddr_i == sslind_pkg::OFS_CTRL) begin
      ctrl_nxt = {31'h0, pwdata_i[sslind_pkg::CTRL_FORCE_BIT]};
    end
    if (psel_i && !penable_i) begin
      prdata_nxt = 32'h0;
      case (paddr_i)
        sslind_pkg::OFS_CTRL: prdata_nxt = ctrl_r;
        sslind_pkg::OFS_STATUS: begin
          prdata_nxt[sslind_pkg::ST_OUT_BIT] = out_en_r;
          prdata_nxt[sslind_pkg::ST_ALERT_BIT] = mode_r == sslind_pkg::MODE_ALERT;
          prdata_nxt[sslind_pkg::ST_ERR_BIT] = mode_r == sslind_pkg::MODE_ERROR;
          prdata_nxt[sslind_pkg::ST_APP_LSB +: sslind_pkg::SEL_W] =
            sel_cap_r[SW2-1 -: sslind_pkg::SEL_W];
          prdata_nxt[sslind_pkg::ST_START_LSB +: sslind_pkg::SEL_W] =
            sel_cap_r[sslind_pkg::SEL_W-1:0];
        end
        sslind_pkg::OFS_ERR: prdata_nxt[sslind_pkg::ERR_W-1:0] = err_r;
        sslind_pkg::OFS_ALERT: begin
          prdata_nxt[sslind_pkg::AL_SYNC_LSB +: NPAIR] = sync_timeout_i;
          prdata_nxt[sslind_pkg::AL_ILK_LSB +: NPAIR] = ilk_r;
          prdata_nxt[sslind_pkg::AL_ANTI_LSB +: NPAIR] = antivalent_i;
        end
        default: prdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= sslind_pkg::MODE_RUN;
      out_en_r <= 1'b0;
      ctrl_r <= sslind_pkg::CTRL_RST;
      prdata_r <= 32'h0;
    end else begin
      mode_r <= mode_nxt;
      out_en_r <= out_en_nxt;
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !(paddr_i == sslind_pkg::OFS_CTRL ||
                     paddr_i == sslind_pkg::OFS_STATUS || paddr_i == sslind_pkg::OFS_ERR ||
                     paddr_i == sslind_pkg::OFS_ALERT);
  assign prdata_o = prdata_r;

  // LED pattern encoder.
  logic pwr_r, state_r, start_r, error_r;
  logic pwr_nxt, state_nxt, start_nxt, error_nxt;
  logic [NIN-1:0] in_led_r;
  logic [NIN-1:0] in_led_nxt;
  logic shown;

  always_comb begin
    pwr_nxt = 1'b1;
    error_nxt = 1'b0;
    state_nxt = out_en_r;
    start_nxt = start_met_i ? 1'b1 : (start_wait_i ? ph : 1'b0);
    in_led_nxt = in_sync_r;
    shown = 1'b0;
    if (mode_r == sslind_pkg::MODE_ERROR) begin
      error_nxt = 1'b1;
      state_nxt = 1'b0;
      start_nxt = 1'b0;
      in_led_nxt = '0;
      if (err_r[sslind_pkg::ERR_CFG_BIT]) begin
        state_nxt = 1'b1;
        start_nxt = 1'b1;
        in_led_nxt = '1;
      end else if (err_r[sslind_pkg::ERR_GEN_BIT]) begin
        state_nxt = ph;
        start_nxt = ph;
        in_led_nxt = {NIN{ph}};
      end else if (err_r[sslind_pkg::ERR_SUP_BIT]) begin
        pwr_nxt = ph;
      end else if (err_r[sslind_pkg::ERR_OUT_BIT]) begin
        state_nxt = ph;
      end else if (err_r[sslind_pkg::ERR_EXT_BIT]) begin
        state_nxt = ph;
        start_nxt = ph;
      end else if (err_r[sslind_pkg::ERR_SXC_BIT]) begin
        start_nxt = ph;
      end else begin
        for (int p = 0; p < NPAIR; p++) begin
          if (err_r[sslind_pkg::ERR_PXC_LSB + p]) begin
            in_led_nxt[p] = ph;
            in_led_nxt[p+1] = ph;
          end
        end
        for (int i = 0; i < NIN; i++) begin
          if (err_r[sslind_pkg::ERR_IXC_LSB + i]) begin
            in_led_nxt[i] = ph;
          end
        end
      end
    end else if (mode_r == sslind_pkg::MODE_ALERT) begin
      error_nxt = ph;
      // Only the first pair in alert is drawn, so patterns never overlap.
      for (int p = 0; p < NPAIR; p++) begin
        if (!shown) begin
          if (sync_timeout_i[p]) begin
            in_led_nxt[p] = ph;
            in_led_nxt[p+1] = ~ph;
            shown = 1'b1;
          end else if (ilk_r[p]) begin
            in_led_nxt[p] = ph;
            in_led_nxt[p+1] = ph;
            shown = 1'b1;
          end else if (antivalent_i[p]) begin
            in_led_nxt[p] = 1'b1;
            in_led_nxt[p+1] = 1'b1;
            shown = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_r <= 1'b0;
      state_r <= 1'b0;
      start_r <= 1'b0;
      error_r <= 1'b0;
      in_led_r <= '0;
    end else begin
      pwr_r <= pwr_nxt;
      state_r <= state_nxt;
      start_r <= start_nxt;
      error_r <= error_nxt;
      in_led_r <= in_led_nxt;
    end
  end

  assign safe_out_en_o = out_en_r;
  assign led_power_o = pwr_r;
  assign led_state_o = state_r;
  assign led_start_o = start_r;
  assign led_in_o = in_led_r;
  assign led_error_o = error_r;
  assign cfg_app_o = sel_cap_r[SW2-1 -: sslind_pkg::SEL_W];
  assign cfg_start_o = sel_cap_r[sslind_pkg::SEL_W-1:0];

endmodule
`default_nettype wire

// >>> testbench/sslind_panel.sv
// Operator view of the panel: which LEDs were seen lit and which dark.
`timescale 1ns/10ps
`default_nettype none
module sslind_panel (
  input wire logic clk_sys_i,
  input wire logic clear_i,
  input wire logic [6:0] led_i,
  output logic [6:0] seen_on_o,
  output logic [6:0] seen_off_o
);
  // Seen both lit and dark in one window means flashing.
  always_ff @(posedge clk_sys_i) begin
    seen_on_o <= clear_i ? 7'h00 : (seen_on_o | led_i);
    seen_off_o <= clear_i ? 7'h00 : (seen_off_o | ~led_i);
  end
endmodule
`default_nettype wire

// >>> testbench/sslind_props.sv
// Port checker for the LED indicator block.
`timescale 1ns/10ps
`default_nettype none
module sslind_props #(
  parameter int unsigned FLASH_HALF_CYC = 8,
  parameter int unsigned QUIET_CYC = 20
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pslverr_o,
  input wire logic [sslind_pkg::NPAIR-1:0] sync_timeout_i,
  input wire logic [sslind_pkg::NPAIR-1:0] interlock_i,
  input wire logic [sslind_pkg::NPAIR-1:0] antivalent_i,
  input wire logic general_fault_i,
  input wire logic supply_fault_i,
  input wire logic out_fault_i,
  input wire logic ext_fault_i,
  input wire logic start_xc_i,
  input wire logic [sslind_pkg::NIN-1:0] in_xc_i,
  input wire logic [sslind_pkg::NPAIR-1:0] pair_xc_i,
  input wire logic safe_out_en_o,
  input wire logic led_power_o,
  input wire logic [sslind_pkg::NIN-1:0] led_in_o,
  input wire logic led_error_o,
  input wire logic [sslind_pkg::SEL_W-1:0] cfg_app_o
);
  logic fault;
  logic err_r, err_nxt, sup_r, sup_nxt;
  logic [3:0] age_r, age_nxt;
  assign fault = general_fault_i | supply_fault_i | out_fault_i | ext_fault_i | start_xc_i
    | (|in_xc_i) | (|pair_xc_i);
  // Age saturates so that checks on settled outputs skip the boot pipeline.
  always_comb begin
    err_nxt = err_r | fault;
    sup_nxt = sup_r | supply_fault_i;
    age_nxt = (age_r == 4'hf) ? age_r : age_r + 4'h1;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_r <= 1'b0;
      sup_r <= 1'b0;
      age_r <= 4'h0;
    end else begin
      err_r <= err_nxt;
      sup_r <= sup_nxt;
      age_r <= age_nxt;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_err_shown;
    ##3 led_error_o [*8];
  endsequence
  sequence s_safe_held;
    ##2 !safe_out_en_o [*8];
  endsequence
  a_err_led_steady: assert property (fault |-> s_err_shown)
    else $error("Error LED not held after a fault.");
  a_err_safe_off: assert property (fault |-> s_safe_held)
    else $error("Outputs on after a fault.");
  a_alert_safe_off: assert property (
    (|sync_timeout_i) || (|antivalent_i) |-> ##2 !safe_out_en_o)
    else $error("Outputs on during an alert.");
  a_ilk_out_hold: assert property ((|interlock_i) |-> ##3 !safe_out_en_o [*8])
    else $error("Outputs on during interlock hold.");
  a_sync_antiphase: assert property (
    (!err_r && sync_timeout_i[0]) [*4] |-> led_in_o[0] != led_in_o[1])
    else $error("Pair LEDs not in antiphase.");
  a_anti_steady: assert property ((!err_r && antivalent_i[0] && !sync_timeout_i[0]) [*4]
    |-> &led_in_o[1:0])
    else $error("Pair LEDs not steady.");
  a_power_steady: assert property (age_r == 4'hf && !sup_r |-> led_power_o)
    else $error("Power LED dark without supply fault.");
  a_cfg_frozen: assert property (age_r == 4'hf |-> $stable(cfg_app_o))
    else $error("Selector copy changed after boot.");
  // Only the four aligned words at the bottom of the map are decoded.
  a_unmapped_err: assert property (psel_i && penable_i |->
    pslverr_o == (paddr_i[7:4] != 4'h0 || paddr_i[1:0] != 2'h0))
    else $error("Bus error flag wrong.");
endmodule
bind sslind_top sslind_props #(.FLASH_HALF_CYC(FLASH_HALF_CYC), .QUIET_CYC(QUIET_CYC)) u_props (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .pslverr_o(pslverr_o), .sync_timeout_i(sync_timeout_i),
  .interlock_i(interlock_i), .antivalent_i(antivalent_i), .general_fault_i(general_fault_i),
  .supply_fault_i(supply_fault_i), .out_fault_i(out_fault_i), .ext_fault_i(ext_fault_i),
  .start_xc_i(start_xc_i), .in_xc_i(in_xc_i), .pair_xc_i(pair_xc_i),
  .safe_out_en_o(safe_out_en_o), .led_power_o(led_power_o), .led_in_o(led_in_o),
  .led_error_o(led_error_o), .cfg_app_o(cfg_app_o));
`default_nettype wire

// >>> testbench/sslind_top_tb.sv
// Self-checking bench for the LED indicator block.
`timescale 1ns/10ps
`default_nettype none
module sslind_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, prdy, perr, err_bit, clear = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [2:0] in_pin = 3'h0, ixc, led_in;
  logic [3:0] sel_app = 4'h3, sel_start = 4'h5, cfg_app, cfg_start;
  logic out_req = 1'b0, st_met = 1'b0, st_wait = 1'b0, gf, sf, of, ef, sxc;
  logic [1:0] sync_t = 2'h0, ilk = 2'h0, anti = 2'h0, pxc;
  logic [9:0] fvec = 10'h000;
  logic safe_out, l_pw, l_st, l_sr, l_er;
  logic [6:0] seen_on, seen_off;
  int bad_count = 0;
  int checks_done = 0;
  assign {gf, sf, of, ef, sxc, ixc, pxc} = fvec;
  always #2.5 clk = ~clk;
  sslind_top #(.FLASH_HALF_CYC(8), .QUIET_CYC(20)) dut_u (
    .clk_sys_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr),
    .in_pin_i(in_pin), .sel_app_pin_i(sel_app), .sel_start_pin_i(sel_start),
    .out_request_i(out_req), .start_met_i(st_met), .start_wait_i(st_wait),
    .sync_timeout_i(sync_t), .interlock_i(ilk), .antivalent_i(anti), .general_fault_i(gf),
    .supply_fault_i(sf), .out_fault_i(of), .ext_fault_i(ef), .start_xc_i(sxc), .in_xc_i(ixc),
    .pair_xc_i(pxc), .safe_out_en_o(safe_out), .led_power_o(l_pw), .led_state_o(l_st),
    .led_start_o(l_sr), .led_in_o(led_in), .led_error_o(l_er), .cfg_app_o(cfg_app),
    .cfg_start_o(cfg_start));
  sslind_panel panel_u (.clk_sys_i(clk), .clear_i(clear),
    .led_i({l_pw, l_st, l_sr, led_in, l_er}), .seen_on_o(seen_on), .seen_off_o(seen_off));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    fvec <= 10'h000;
    sync_t <= 2'h0;
    ilk <= 2'h0;
    anti <= 2'h0;
    in_pin <= 3'h0;
    out_req <= 1'b1;
    cyc(2);
    rst_n <= 1'b1;
    cyc(12);
  endtask
  // Two bits per LED, power first: 01 dark, 10 steady, 11 flashing.
  task automatic look(input logic [13:0] exp, input logic [13:0] mask);
    logic [13:0] got;
    cyc(4);
    clear <= 1'b1;
    cyc(1);
    clear <= 1'b0;
    cyc(40);
    for (int i = 0; i < 7; i++) got[2*i +: 2] = {seen_on[i], seen_off[i]};
    check(got & mask, exp & mask);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rdata = prdata;
    err_bit = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic t_run();
    do_reset();
    in_pin <= 3'h5;
    st_wait <= 1'b1;
    look(14'h2b99, 14'h3fff);
    check(safe_out, 1'b1);
    st_met <= 1'b1;
    look(14'h2a99, 14'h3fff);
    st_met <= 1'b0;
    st_wait <= 1'b0;
    look(14'h2999, 14'h3fff);
    $display("Test run status done");
  endtask
  task automatic t_bus();
    apb(1'b0, sslind_pkg::OFS_STATUS, 32'h0);
    check(rdata[sslind_pkg::ST_OUT_BIT], 1'b1);
    check(rdata[sslind_pkg::ST_APP_LSB +: 4], 4'h3);
    apb(1'b1, sslind_pkg::OFS_CTRL, 32'h1);
    cyc(4);
    check(safe_out, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    check(err_bit, 1'b1);
    check(rdata, 32'h0);
    apb(1'b1, sslind_pkg::OFS_CTRL, 32'h0);
    cyc(4);
    check(safe_out, 1'b1);
    $display("Test register bus done");
  endtask
  task automatic t_alert(input logic [1:0] sy, input logic [1:0] il, input logic [1:0] an,
                         input logic [13:0] exp);
    do_reset();
    in_pin <= 3'h3;
    cyc(8);
    sync_t <= sy;
    ilk <= il;
    anti <= an;
    cyc(1);
    ilk <= 2'h0;
    look(exp, 14'h3cff);
    check(safe_out, 1'b0);
    sync_t <= 2'h0;
    anti <= 2'h0;
    in_pin <= 3'h0;
    cyc(12);
    check(safe_out, il == 2'h0);
    cyc(30);
    check(safe_out, 1'b1);
    $display("Test alert done");
  endtask
  task automatic t_errors();
    logic [9:0] ev [8] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020, 10'h008, 10'h002, 10'h220};
    logic [13:0] pat [8] = '{14'h2ffe, 14'h3556, 14'h2d56, 14'h2f56, 14'h2756, 14'h2576,
                             14'h25f6, 14'h2ffe};
    for (int i = 0; i < 8; i++) begin
      do_reset();
      fvec <= ev[i];
      cyc(1);
      fvec <= 10'h000;
      look(pat[i], 14'h3fff);
      check(safe_out, 1'b0);
    end
    $display("Test errors done");
  endtask
  task automatic t_cfg();
    do_reset();
    check(cfg_app, 4'h3);
    check(cfg_start, 4'h5);
    sel_app <= 4'h6;
    look(14'h2aaa, 14'h3fff);
    check(cfg_app, 4'h3);
    check(safe_out, 1'b0);
    $display("Test selector done");
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    t_run();
    t_bus();
    t_alert(2'h1, 2'h0, 2'h0, 14'h247f);
    t_alert(2'h0, 2'h1, 2'h0, 14'h247f);
    t_alert(2'h0, 2'h0, 2'h1, 14'h246b);
    t_errors();
    t_cfg();
    complete_run();
  end
  // A hang is cut off well past the roughly one thousand cycles the tests need.
  initial begin
    cyc(20000);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
